// [hdl/lvd_defs.svh]
// Register indices, field positions, reset values and timing figures of the detector
`ifndef LVD_DEFS_SVH
`define LVD_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define LVD_ADDR_WIDTH        18
`define LVD_IDX_CONTROL       16'hFFBE
`define LVD_IDX_STATUS        16'hFFC0
`define LVD_IDX_CLEAR         16'hFFC1
`define LVD_IDX_IRQ_ENABLE    16'hFFC2

// ****************************************************************
// Control register fields
// ****************************************************************
`define LVD_BIT_ENABLE        7
`define LVD_BIT_SOURCE        2
`define LVD_BIT_MODE          1
`define LVD_BIT_FLAG          0
`define LVD_CONTROL_RESET     8'h00

// ****************************************************************
// Event status fields
// ****************************************************************
`define LVD_EVT_WIDTH         2
`define LVD_EVT_FELL          0
`define LVD_EVT_ROSE          1
`define LVD_EVT_RESET         2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define LVD_CLK_PERIOD_NS     50
`define LVD_SETTLE_TIME_US    10
`define LVD_QUALIFY_TIME_US   200

`endif

// [hdl/lvd_pkg.sv]
// Types shared by the low-voltage detector modules
`default_nettype none
package lvd_pkg;

	typedef enum logic [1:0] {
		RESP_OKAY   = 2'h0,
		RESP_SLVERR = 2'h2
	} axi_resp_t;

	typedef enum logic [1:0] {
		DET_OFF    = 2'h0,
		DET_SETTLE = 2'h1,
		DET_RUN    = 2'h2
	} det_state_t;

	typedef enum logic [2:0] {
		SEL_NONE       = 3'h0,
		SEL_CONTROL    = 3'h1,
		SEL_STATUS     = 3'h2,
		SEL_CLEAR      = 3'h3,
		SEL_IRQ_ENABLE = 3'h4
	} reg_sel_t;

endpackage : lvd_pkg
`default_nettype wire

// [hdl/detect_if.sv]
// Carrier between the detector core and its below-threshold qualifier
`default_nettype none
interface detect_if;
	logic arm;
	logic below_raw;
	logic below_qualified;

	modport core  (output arm, output below_raw, input below_qualified);
	modport timer (input arm, input below_raw, output below_qualified);
endinterface : detect_if
`default_nettype wire

// [hdl/level_sync.sv]
// Three-stage synchroniser for a comparator level arriving from the analogue side
`default_nettype none
module level_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Level
	input  wire logic async_in,
	output var  logic sync_out
);
	logic stage1;
	logic stage2;
	logic stage3;

	// Stage one feeds stage two only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_out <= 1'b0;
		end else if (stage2 == stage3) begin
			sync_out <= stage3;
		end
	end
endmodule : level_sync
`default_nettype wire

// [hdl/below_qualifier.sv]
// Holds off the below-threshold flag until the level has stood for the qualify time
`default_nettype none
module below_qualifier #(
	parameter int QUALIFY_CYCLES = 4000
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Detector core
	detect_if.timer   det
);
	localparam int CW = $clog2(QUALIFY_CYCLES + 1);

	logic [CW-1:0] count;

	// Any return to or above threshold restarts the wait
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count               <= '0;
			det.below_qualified <= 1'b0;
		end else if (!det.arm || !det.below_raw) begin
			count               <= '0;
			det.below_qualified <= 1'b0;
		end else if (count == CW'(QUALIFY_CYCLES - 1)) begin
			det.below_qualified <= 1'b1;
		end else begin
			count <= count + CW'(1);
		end
	end
endmodule : below_qualifier
`default_nettype wire

// [hdl/low_voltage_detect_ctrl.sv]
// Low-voltage detector control register, flag, events and AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite register port.
`include "lvd_defs.svh"
`default_nettype none
module low_voltage_detect_ctrl #(
	parameter int ADDR_WIDTH     = `LVD_ADDR_WIDTH,
	parameter int SETTLE_CYCLES  = (`LVD_SETTLE_TIME_US * 1000) / `LVD_CLK_PERIOD_NS,
	parameter int QUALIFY_CYCLES = (`LVD_QUALIFY_TIME_US * 1000 + `LVD_CLK_PERIOD_NS - 1)
	                               / `LVD_CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire logic                  CORE_CLK,
	input  wire logic                  RST,
	// AXI4-Lite write address
	input  wire logic [ADDR_WIDTH-1:0] AWADDR,
	input  wire logic                  AWVALID,
	output var  logic                  AWREADY,
	// AXI4-Lite write data
	input  wire logic [31:0]           WDATA,
	input  wire logic [3:0]            WSTRB,
	input  wire logic                  WVALID,
	output var  logic                  WREADY,
	// AXI4-Lite write response
	output var  lvd_pkg::axi_resp_t    BRESP,
	output var  logic                  BVALID,
	input  wire logic                  BREADY,
	// AXI4-Lite read address
	input  wire logic [ADDR_WIDTH-1:0] ARADDR,
	input  wire logic                  ARVALID,
	output var  logic                  ARREADY,
	// AXI4-Lite read data
	output var  logic [31:0]           RDATA,
	output var  lvd_pkg::axi_resp_t    RRESP,
	output var  logic                  RVALID,
	input  wire logic                  RREADY,
	// Analogue comparator
	input  wire logic                  SUPPLY_BELOW,
	input  wire logic                  PIN_BELOW,
	output var  logic                  COMPARATOR_ENABLE,
	output var  logic                  SOURCE_SELECT,
	// System
	output var  logic                  DETECT_RESET,
	output var  logic                  IRQ
);
	import lvd_pkg::*;

	localparam int IW = ADDR_WIDTH - 2;
	localparam int SW = $clog2(SETTLE_CYCLES + 1);
	localparam int EW = `LVD_EVT_WIDTH;

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic reg_sel_t decode(input logic [ADDR_WIDTH-1:0] addr);
		logic [IW-1:0] idx;
		idx = addr[ADDR_WIDTH-1:2];
		case (idx)
			IW'(`LVD_IDX_CONTROL):    decode = SEL_CONTROL;
			IW'(`LVD_IDX_STATUS):     decode = SEL_STATUS;
			IW'(`LVD_IDX_CLEAR):      decode = SEL_CLEAR;
			IW'(`LVD_IDX_IRQ_ENABLE): decode = SEL_IRQ_ENABLE;
			default:                  decode = SEL_NONE;
		endcase
	endfunction : decode

	// ****************************************************************
	// Declarations
	// ****************************************************************
	// Control register fields
	logic          detect_enable;
	logic          source_select;
	logic          action_mode_select;
	logic          below_threshold_flag;
	// Event and interrupt registers
	logic [EW-1:0] event_status;
	logic [EW-1:0] event_enable;
	// Detector sequencing
	det_state_t    state;
	logic [SW-1:0] settle_count;
	logic          supply_below_sync;
	logic          pin_below_sync;
	logic          next_flag;
	logic          fell_event;
	logic          rose_event;
	// Bus side
	logic                  aw_held;
	logic                  w_held;
	logic [ADDR_WIDTH-1:0] aw_addr;
	logic [7:0]            w_byte;
	logic                  write_fire;
	reg_sel_t              write_sel;
	reg_sel_t              read_sel;
	logic [31:0]           read_word;

	detect_if det ();

	// ****************************************************************
	// Comparator synchronisers
	// ****************************************************************
	level_sync supply_sync (
		.clk      (CORE_CLK),
		.rst      (RST),
		.async_in (SUPPLY_BELOW),
		.sync_out (supply_below_sync)
	);

	level_sync pin_sync (
		.clk      (CORE_CLK),
		.rst      (RST),
		.async_in (PIN_BELOW),
		.sync_out (pin_below_sync)
	);

	// ****************************************************************
	// Below-threshold qualification
	// ****************************************************************
	assign det.arm       = (state == DET_RUN);
	assign det.below_raw = source_select ? pin_below_sync : supply_below_sync;

	below_qualifier #(
		.QUALIFY_CYCLES (QUALIFY_CYCLES)
	) qualifier (
		.clk (CORE_CLK),
		.rst (RST),
		.det (det.timer)
	);

	// ****************************************************************
	// Detector sequencing
	// ****************************************************************
	// The comparator is ignored while it settles, so stale levels never raise events
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state        <= DET_OFF;
			settle_count <= '0;
		end else begin
			case (state)
				DET_OFF: begin
					settle_count <= '0;
					if (detect_enable) begin
						state <= DET_SETTLE;
					end
				end
				DET_SETTLE: begin
					if (!detect_enable) begin
						state <= DET_OFF;
					end else if (settle_count == SW'(SETTLE_CYCLES - 1)) begin
						state <= DET_RUN;
					end else begin
						settle_count <= settle_count + SW'(1);
					end
				end
				DET_RUN: begin
					if (!detect_enable) begin
						state <= DET_OFF;
					end
				end
				default: begin
					state <= DET_OFF;
				end
			endcase
		end
	end

	// ****************************************************************
	// Flag, crossings and detector reset
	// ****************************************************************
	always_comb begin
		next_flag  = detect_enable && (state == DET_RUN) && det.below_qualified;
		fell_event = !action_mode_select && next_flag && !below_threshold_flag;
		rose_event = !action_mode_select && !next_flag && below_threshold_flag
		             && detect_enable && (state == DET_RUN);
	end

	// Only hardware moves the flag
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			below_threshold_flag <= 1'b0;
		end else begin
			below_threshold_flag <= next_flag;
		end
	end

	// Held for the whole below-threshold period; must never feed RST back
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			DETECT_RESET <= 1'b0;
		end else begin
			DETECT_RESET <= action_mode_select && next_flag;
		end
	end

	// ****************************************************************
	// Comparator controls
	// ****************************************************************
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			COMPARATOR_ENABLE <= 1'b0;
			SOURCE_SELECT     <= 1'b0;
		end else begin
			COMPARATOR_ENABLE <= detect_enable;
			SOURCE_SELECT     <= source_select;
		end
	end

	// ****************************************************************
	// Control register
	// ****************************************************************
	// Only RST clears the settings; the detector's own reset output does not
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			detect_enable      <= 1'(`LVD_CONTROL_RESET >> `LVD_BIT_ENABLE);
			source_select      <= 1'b0;
			action_mode_select <= 1'b0;
		end else if (write_fire && write_sel == SEL_CONTROL) begin
			detect_enable      <= w_byte[`LVD_BIT_ENABLE];
			source_select      <= w_byte[`LVD_BIT_SOURCE];
			action_mode_select <= w_byte[`LVD_BIT_MODE];
		end
	end

	// ****************************************************************
	// Event status, enable and interrupt
	// ****************************************************************
	// A crossing in the same cycle as its clear stays set
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			event_status <= `LVD_EVT_RESET;
		end else begin
			for (int i = 0; i < EW; i++) begin
				if ((i == `LVD_EVT_FELL && fell_event) || (i == `LVD_EVT_ROSE && rose_event)) begin
					event_status[i] <= 1'b1;
				end else if (write_fire && write_sel == SEL_CLEAR && w_byte[i]) begin
					event_status[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			event_enable <= `LVD_EVT_RESET;
		end else if (write_fire && write_sel == SEL_IRQ_ENABLE) begin
			event_enable <= w_byte[EW-1:0];
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(event_status & event_enable);
		end
	end

	// ****************************************************************
	// AXI4-Lite write path
	// ****************************************************************
	// Address and data are taken in either order and joined before the write
	assign write_fire = aw_held && w_held && !BVALID;
	assign write_sel  = decode(aw_addr);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			AWREADY <= 1'b0;
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else begin
			AWREADY <= AWVALID && !AWREADY && !aw_held;
			if (AWVALID && AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR;
			end else if (write_fire) begin
				aw_held <= 1'b0;
			end
		end
	end

	// A write without lane 0 stores 00H, so it also stops detection
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			WREADY <= 1'b0;
			w_held <= 1'b0;
			w_byte <= 8'h00;
		end else begin
			WREADY <= WVALID && !WREADY && !w_held;
			if (WVALID && WREADY) begin
				w_held <= 1'b1;
				w_byte <= WSTRB[0] ? WDATA[7:0] : 8'h00;
			end else if (write_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			BVALID <= 1'b0;
			BRESP  <= RESP_OKAY;
		end else if (write_fire) begin
			BVALID <= 1'b1;
			BRESP  <= (write_sel == SEL_NONE || write_sel == SEL_STATUS) ? RESP_SLVERR
			                                                             : RESP_OKAY;
		end else if (BVALID && BREADY) begin
			BVALID <= 1'b0;
		end
	end

	// ****************************************************************
	// AXI4-Lite read path
	// ****************************************************************
	assign read_sel = decode(ARADDR);

	always_comb begin
		read_word = 32'h0000_0000;
		case (read_sel)
			SEL_CONTROL: begin
				read_word[`LVD_BIT_ENABLE] = detect_enable;
				read_word[`LVD_BIT_SOURCE] = source_select;
				read_word[`LVD_BIT_MODE]   = action_mode_select;
				read_word[`LVD_BIT_FLAG]   = below_threshold_flag;
			end
			SEL_STATUS:     read_word[EW-1:0] = event_status;
			SEL_IRQ_ENABLE: read_word[EW-1:0] = event_enable;
			default:        read_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ARREADY <= 1'b0;
		end else begin
			ARREADY <= ARVALID && !ARREADY && !RVALID;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			RVALID <= 1'b0;
			RDATA  <= 32'h0000_0000;
			RRESP  <= RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RDATA  <= read_word;
			RRESP  <= (read_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end

endmodule : low_voltage_detect_ctrl
`default_nettype wire

// [verification/lvd_checker.sv]
// Port assertions for the low-voltage detector
`default_nettype none
module lvd_checker #(
	parameter int QUALIFY_CYCLES = 4000
) (
	// Clock and reset
	input wire logic               CORE_CLK,
	input wire logic               RST,
	// Bus answers
	input wire logic               BVALID,
	input wire logic               BREADY,
	input wire lvd_pkg::axi_resp_t BRESP,
	input wire logic               RVALID,
	input wire logic               RREADY,
	input wire logic [31:0]        RDATA,
	// Comparator and system
	input wire logic               SUPPLY_BELOW,
	input wire logic               PIN_BELOW,
	input wire logic               COMPARATOR_ENABLE,
	input wire logic               SOURCE_SELECT,
	input wire logic               DETECT_RESET,
	input wire logic               IRQ
);
	import lvd_pkg::*;
	logic        sel_below;
	logic [15:0] below_count;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// ****************************************************************
	// Helper: cycles the selected level has stood below while running
	// ****************************************************************
	assign sel_below = SOURCE_SELECT ? PIN_BELOW : SUPPLY_BELOW;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			below_count <= 16'h0000;
		else if (!COMPARATOR_ENABLE || !sel_below)
			below_count <= 16'h0000;
		else if (below_count != 16'hFFFF)
			below_count <= below_count + 16'h0001;
	end
	// ****************************************************************
	// Properties
	// ****************************************************************
	property p_reset_clear;
		$fell(RST) |-> !COMPARATOR_ENABLE && !SOURCE_SELECT && !DETECT_RESET && !IRQ;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
	property p_off_quiet;
		!COMPARATOR_ENABLE [*3] |-> !DETECT_RESET;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("reset while detector stopped");
	property p_settle;
		$rose(COMPARATOR_ENABLE) |-> !DETECT_RESET [*8];
	endproperty
	a_settle: assert property (p_settle) else $error("reset right after enabling");
	property p_qualify;
		$rose(DETECT_RESET) |-> below_count >= QUALIFY_CYCLES;
	endproperty
	a_qualify: assert property (p_qualify) else $error("reset before qualify time");
	property p_release;
		!sel_below [*8] |-> !DETECT_RESET;
	endproperty
	a_release: assert property (p_release) else $error("reset held above threshold");
	property p_sync;
		$fell(sel_below) && DETECT_RESET && $stable(SOURCE_SELECT) && COMPARATOR_ENABLE
			&& $past(COMPARATOR_ENABLE) |=> DETECT_RESET;
	endproperty
	a_sync: assert property (p_sync) else $error("comparator level used unsynchronised");
	property p_b_hold;
		BVALID && !BREADY |=> BVALID && $stable(BRESP);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold;
		RVALID && !RREADY |=> RVALID && $stable(RDATA);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	c_reset: cover property ($rose(DETECT_RESET));
	c_irq: cover property ($rose(IRQ));
	c_slverr: cover property (BVALID && BRESP == RESP_SLVERR);
endmodule : lvd_checker
bind low_voltage_detect_ctrl lvd_checker #(.QUALIFY_CYCLES(QUALIFY_CYCLES)) lvd_checker_inst (
	.CORE_CLK(CORE_CLK), .RST(RST), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
	.RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .SUPPLY_BELOW(SUPPLY_BELOW),
	.PIN_BELOW(PIN_BELOW), .COMPARATOR_ENABLE(COMPARATOR_ENABLE),
	.SOURCE_SELECT(SOURCE_SELECT), .DETECT_RESET(DETECT_RESET), .IRQ(IRQ));
`default_nettype wire

// [verification/comparator_model.sv]
// Behavioural comparator pair behind the detector
`default_nettype none
module comparator_model (
	// Control from the detector
	input  wire logic enable,
	// Commanded levels
	input  wire logic supply_low,
	input  wire logic pin_low,
	// Comparator outputs
	output var  logic supply_below,
	output var  logic pin_below
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		supply_below = 1'b0;
		pin_below    = 1'b1;
	end
	// A stopped comparator has no valid answer, so it wanders off the clock's pace
	always begin
		#17;
		supply_below = enable ? supply_low : ~supply_below;
		pin_below    = enable ? pin_low : ~pin_below;
	end
endmodule : comparator_model
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the low-voltage detector
`include "lvd_defs.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import lvd_pkg::*;
	localparam int          QUAL  = 16;
	localparam logic [17:0] A_CTL = {`LVD_IDX_CONTROL, 2'b00};
	localparam logic [17:0] A_STS = {`LVD_IDX_STATUS, 2'b00};
	localparam logic [17:0] A_CLR = {`LVD_IDX_CLEAR, 2'b00};
	localparam logic [17:0] A_IEN = {`LVD_IDX_IRQ_ENABLE, 2'b00};
	localparam logic [17:0] A_BAD = 18'h00010;
	typedef struct {string what; logic [31:0] value;} note_t;
	note_t       notes[$];
	int          num_errors, checked, seed, i;
	logic [31:0] d, WDATA, RDATA;
	logic [17:0] AWADDR, ARADDR;
	logic [3:0]  WSTRB;
	logic        CORE_CLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic        ARVALID, ARREADY, RVALID, RREADY, supply_low, pin_low;
	logic        SUPPLY_BELOW, PIN_BELOW, COMPARATOR_ENABLE, SOURCE_SELECT, DETECT_RESET, IRQ;
	axi_resp_t   BRESP, RRESP;
	low_voltage_detect_ctrl #(.SETTLE_CYCLES(4), .QUALIFY_CYCLES(QUAL)) low_voltage_detect_ctrl_inst (
		.CORE_CLK(CORE_CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.SUPPLY_BELOW(SUPPLY_BELOW), .PIN_BELOW(PIN_BELOW), .COMPARATOR_ENABLE(COMPARATOR_ENABLE),
		.SOURCE_SELECT(SOURCE_SELECT), .DETECT_RESET(DETECT_RESET), .IRQ(IRQ));
	comparator_model comparator_model_inst (.enable(COMPARATOR_ENABLE), .supply_low(supply_low),
		.pin_low(pin_low), .supply_below(SUPPLY_BELOW), .pin_below(PIN_BELOW));
	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out();
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic take(input logic [31:0] seen);
		note_t n;
		if (notes.size() == 0) begin
			num_errors++;
			$display("Error response expected none seen %h", seen);
		end else begin
			n = notes.pop_front();
			check(n.what, seen, n.value);
		end
	endtask : take
	// Responses are judged where they appear, against the oldest note
	always @(posedge CORE_CLK) begin
		if (BVALID && BREADY)
			take({30'h0, BRESP});
		if (RVALID && RREADY) begin
			take(RDATA);
			take({30'h0, RRESP});
		end
	end
	// ****************************************************************
	// Bus master
	// ****************************************************************
	task automatic axi_write(input logic [17:0] a, input logic [31:0] wd, input logic [3:0] s,
			input axi_resp_t r);
		int n;
		@(posedge CORE_CLK);
		notes.push_back('{"BRESP", {30'h0, r}});
		AWADDR  <= a;
		WDATA   <= wd;
		WSTRB   <= s;
		AWVALID <= 1'b1;
		WVALID  <= 1'b1;
		BREADY  <= 1'($random(seed));
		for (n = 0; n < 40; n++) begin
			@(posedge CORE_CLK);
			if (AWREADY)
				AWVALID <= 1'b0;
			if (WREADY)
				WVALID <= 1'b0;
			if (BVALID && BREADY)
				break;
			if (BVALID)
				BREADY <= 1'b1;
		end
		BREADY <= 1'b0;
		if (n == 40)
			num_errors++;
		if (n == 40)
			close_out();
	endtask : axi_write
	task automatic axi_read(input logic [17:0] a, input logic [31:0] rd, input axi_resp_t r);
		int n;
		@(posedge CORE_CLK);
		notes.push_back('{"RDATA", rd});
		notes.push_back('{"RRESP", {30'h0, r}});
		ARADDR  <= a;
		ARVALID <= 1'b1;
		RREADY  <= 1'($random(seed));
		for (n = 0; n < 40; n++) begin
			@(posedge CORE_CLK);
			if (ARREADY)
				ARVALID <= 1'b0;
			if (RVALID && RREADY)
				break;
			if (RVALID)
				RREADY <= 1'b1;
		end
		RREADY <= 1'b0;
		if (n == 40)
			num_errors++;
		if (n == 40)
			close_out();
	endtask : axi_read
	task automatic wait_level(input string what, input logic lvl, input int lim);
		int n;
		for (n = 0; n < lim; n++) begin
			@(posedge CORE_CLK);
			if ((what == "IRQ" ? IRQ : DETECT_RESET) === lvl)
				break;
		end
		check(what, {31'h0, what == "IRQ" ? IRQ : DETECT_RESET}, {31'h0, lvl});
	endtask : wait_level
	// ****************************************************************
	// Clock, watchdog and scenarios
	// ****************************************************************
	initial begin
		CORE_CLK = 1'b0;
		forever #25 CORE_CLK = ~CORE_CLK;
	end
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		num_errors++;
		close_out();
	end
	initial begin
		{AWADDR, ARADDR, WDATA, WSTRB, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
		{supply_low, pin_low, num_errors, checked} = '0;
		seed = 54;
		RST  = 1'b1;
		repeat (16) @(posedge CORE_CLK);
		RST <= 1'b0;
		axi_read(A_CTL, 32'h0, RESP_OKAY);
		axi_read(A_STS, 32'h0, RESP_OKAY);
		axi_read(A_IEN, 32'h0, RESP_OKAY);
		axi_read(A_CLR, 32'h0, RESP_OKAY);
		axi_read(A_BAD, 32'h0, RESP_SLVERR);
		axi_write(A_BAD, 32'hFF, 4'hF, RESP_SLVERR);
		axi_write(A_STS, 32'h3, 4'hF, RESP_SLVERR);
		axi_write(A_CTL, 32'h01, 4'hF, RESP_OKAY);
		axi_read(A_CTL, 32'h0, RESP_OKAY);
		// Random settings with both levels above threshold
		for (i = 0; i < 6; i++) begin
			d = $random(seed);
			axi_write(A_CTL, d, 4'hF, RESP_OKAY);
			axi_read(A_CTL, d & 32'h86, RESP_OKAY);
		end
		axi_write(A_CTL, 32'h02, 4'hF, RESP_OKAY);
		axi_write(A_CLR, 32'h3, 4'hF, RESP_OKAY);
		supply_low <= 1'b1;
		repeat (QUAL + 40) @(posedge CORE_CLK);
		check("DETECT_RESET", {31'h0, DETECT_RESET}, 32'h0);
		axi_read(A_CTL, 32'h02, RESP_OKAY);
		// Reset mode on the supply rail
		axi_write(A_CTL, 32'h82, 4'hF, RESP_OKAY);
		repeat (QUAL) @(posedge CORE_CLK);
		check("COMPARATOR_ENABLE", {31'h0, COMPARATOR_ENABLE}, 32'h1);
		check("DETECT_RESET", {31'h0, DETECT_RESET}, 32'h0);
		wait_level("DETECT_RESET", 1'b1, 60);
		axi_read(A_CTL, 32'h83, RESP_OKAY);
		supply_low <= 1'b0;
		wait_level("DETECT_RESET", 1'b0, 20);
		axi_read(A_CTL, 32'h82, RESP_OKAY);
		// Pin source: a low supply no longer counts
		supply_low <= 1'b1;
		axi_write(A_CTL, 32'h86, 4'hF, RESP_OKAY);
		repeat (QUAL + 40) @(posedge CORE_CLK);
		check("DETECT_RESET", {31'h0, DETECT_RESET}, 32'h0);
		check("SOURCE_SELECT", {31'h0, SOURCE_SELECT}, 32'h1);
		pin_low <= 1'b1;
		wait_level("DETECT_RESET", 1'b1, 60);
		axi_read(A_CTL, 32'h87, RESP_OKAY);
		pin_low <= 1'b0;
		wait_level("DETECT_RESET", 1'b0, 20);
		// Interrupt mode: both crossings, masking and clearing
		axi_write(A_CLR, 32'h3, 4'hF, RESP_OKAY);
		axi_write(A_IEN, 32'h3, 4'hF, RESP_OKAY);
		axi_write(A_CTL, 32'h80, 4'hF, RESP_OKAY);
		wait_level("IRQ", 1'b1, 60);
		axi_read(A_STS, 32'h1, RESP_OKAY);
		axi_read(A_CTL, 32'h81, RESP_OKAY);
		check("DETECT_RESET", {31'h0, DETECT_RESET}, 32'h0);
		axi_write(A_CLR, 32'h1, 4'hF, RESP_OKAY);
		wait_level("IRQ", 1'b0, 5);
		supply_low <= 1'b0;
		wait_level("IRQ", 1'b1, 20);
		axi_read(A_STS, 32'h2, RESP_OKAY);
		axi_write(A_IEN, 32'h1, 4'hF, RESP_OKAY);
		wait_level("IRQ", 1'b0, 5);
		axi_read(A_STS, 32'h2, RESP_OKAY);
		// Stop by a byte write of 00H while the flag is set
		axi_write(A_CLR, 32'h3, 4'hF, RESP_OKAY);
		supply_low <= 1'b1;
		repeat (QUAL + 20) @(posedge CORE_CLK);
		axi_read(A_CTL, 32'h81, RESP_OKAY);
		axi_write(A_CTL, 32'h00, 4'h1, RESP_OKAY);
		axi_read(A_CTL, 32'h00, RESP_OKAY);
		check("COMPARATOR_ENABLE", {31'h0, COMPARATOR_ENABLE}, 32'h0);
		// Outside reset in mid-run clears the settings
		axi_write(A_CTL, 32'h82, 4'hF, RESP_OKAY);
		wait_level("DETECT_RESET", 1'b1, 60);
		@(posedge CORE_CLK);
		RST <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		RST <= 1'b0;
		check("DETECT_RESET", {31'h0, DETECT_RESET}, 32'h0);
		axi_read(A_CTL, 32'h00, RESP_OKAY);
		// Stop by clearing the enable bit alone
		axi_write(A_CTL, 32'h82, 4'hF, RESP_OKAY);
		wait_level("DETECT_RESET", 1'b1, 60);
		axi_write(A_CTL, 32'h02, 4'hF, RESP_OKAY);
		wait_level("DETECT_RESET", 1'b0, 4);
		axi_read(A_CTL, 32'h02, RESP_OKAY);
		close_out();
	end
endmodule : testbench
`default_nettype wire
